// ==== design/tla_pkg.sv ====
/*
 Package for the terminal line activation state machine: states, line
 signal codes, indication bundle and timing constants.
 Assumes a 20 MHz system clock.
*/
package tla_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned SYNC_TIME_MS = 100;
   localparam int unsigned SILENCE_TIME_MS = 5;
   localparam int unsigned ACT_TIMER_MS = 29000;
   localparam int unsigned SYNC_CYCLES = SYNC_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned SILENCE_CYCLES = SILENCE_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned ACT_TIMER_CYCLES = ACT_TIMER_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMER_W = 32;
   localparam int unsigned NDF_FRAMES = 2;
   localparam int unsigned WAKE_LEN = 8;
   // Positive zero, negative zero, six ones; 2'b01 pos zero, 2'b10 neg zero, 2'b00 one
   localparam logic [15:0] WAKE_SEQ = 16'h6000;

   typedef enum logic [7:0] {
      TLA_UNPOWERED = 8'h01,
      TLA_SENSING = 8'h02,
      TLA_DEACTIVATED = 8'h04,
      TLA_AWAITING = 8'h08,
      TLA_IDENTIFYING = 8'h10,
      TLA_SYNCHRONIZED = 8'h20,
      TLA_ACTIVATED = 8'h40,
      TLA_LOST_FRAMING = 8'h80
   } tla_state_type;

   typedef enum logic [1:0] {
      TLA_TX_SILENCE = 2'h0,
      TLA_TX_WAKEUP = 2'h1,
      TLA_TX_DATA = 2'h2
   } tla_tx_type;

   // Line events decoded by the receiver
   typedef struct packed {
      logic any_signal;
      logic idle_frame;
      logic network_frame;
      logic frame_lost;
      logic silence;
   } tla_rx_type;

   // One-cycle indications to layer 2 and management
   typedef struct packed {
      logic layer2_activation;
      logic mgmt_activation;
      logic layer2_deactivation;
      logic mgmt_deactivation;
      logic connected_report;
      logic disconnected_report;
      logic mgmt_error;
   } tla_ind_type;
endpackage

// ==== design/tla_wakeup_gen.sv ====
/*
 Wakeup pattern generator: emits a repeating pattern of eight two-bit line symbols.
 Assumes bit_tick_i pulses at the line bit rate (nominally 192 kbit/s).
*/
`timescale 1ns/10ps
`default_nettype none
module tla_wakeup_gen (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // Control
   input wire logic enable_i,
   input wire logic bit_tick_i,
   // Symbol out
   output logic [1:0] symbol_o
);
   import tla_pkg::*;
   logic [2:0] pos;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pos <= 3'h0;
         symbol_o <= 2'h0;
      end else if (ce_i) begin
         if (!enable_i) begin
            pos <= 3'h0;
            symbol_o <= 2'h0;
         end else if (bit_tick_i) begin
            symbol_o <= WAKE_SEQ[15 - 2 * pos -: 2];
            pos <= pos + 3'h1;
         end
      end
   end

   // The position counter wraps at eight symbols
   if (WAKE_LEN != 8) begin : g_bad_len
      $error("wakeup pattern needs eight symbols");
   end

   property p_idle_symbol;
      @(posedge clk_i) disable iff (!nrst_i) ce_i && !enable_i |=> symbol_o == 2'h0;
   endproperty
   a_idle_symbol : assert property (p_idle_symbol) else $error("wakeup symbol not cleared");

   property p_first_symbol;
      @(posedge clk_i) disable iff (!nrst_i) ce_i && enable_i && bit_tick_i && pos == 3'h0
         |=> symbol_o == 2'h1;
   endproperty
   a_first_symbol : assert property (p_first_symbol) else $error("wakeup not led by pos zero");
endmodule // tla_wakeup_gen
`default_nettype wire

// ==== design/tla_fsm.sv ====
/*
 User terminal layer 1 activation/deactivation state machine.
 Assumes line events arrive decoded and synchronous to clk_i.
*/
// What this block does
// - Send silence on connection, power-up and loss of frame alignment.
// - A powered but disconnected terminal sends silence when connected; wakeup needs a request in deactivated.
// - Send terminal data frames once frame alignment is established.
// - Data transfer is only reliable after network data frames are received.
// - On local power loss, switch to silence before alignment is lost.
// - From deactivated, sync and send data frames within 100 ms of a frame.
// - In synchronized, recognize network data frames within two good frames.
// - In awaiting, stop wakeup within 5 ms, then sync within 100 ms.
// - From awaiting, any incoming signal enters identifying.
// - Transmitted signal follows the state.
// - Power detection enters sensing; loss returns to unpowered with reports.
// - Activation request starts timer under 30 s; expiry reports and deactivates.
// - Wakeup is positive zero, negative zero, six ones, repeating.
`timescale 1ns/10ps
`default_nettype none
module tla_fsm #(
   parameter int unsigned ACT_CYCLES = tla_pkg::ACT_TIMER_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // Power and requests
   input wire logic power_i,
   input wire logic activation_request_i,
   // Line receive side
   input wire tla_pkg::tla_rx_type rx_i,
   input wire logic bit_tick_i,
   // Transmit side
   output tla_pkg::tla_tx_type tx_sel_o,
   output logic [1:0] wake_symbol_o,
   output logic data_reliable_o,
   // Indications
   output tla_pkg::tla_ind_type ind_o,
   output tla_pkg::tla_state_type state_o
);
   import tla_pkg::*;

   if (ACT_CYCLES == 0 || ACT_CYCLES >= 30 * CLK_HZ) begin : g_bad_act
      $error("activation timer must lie below 30 s");
   end

   tla_state_type state, next_state;
   tla_ind_type next_ind;
   logic [TIMER_W-1:0] act_count;
   logic act_run, next_act_start, next_act_stop;
   logic act_expired;

   assign act_expired = act_run && (act_count == 32'h1);
   assign state_o = state;

   function automatic logic is_sync_or_later(input tla_state_type s);
      return s inside {TLA_SYNCHRONIZED, TLA_ACTIVATED};
   endfunction

   always_comb begin
      next_state = state;
      next_ind = '0;
      next_act_start = 1'b0;
      next_act_stop = 1'b0;
      if (!power_i) begin
         next_state = TLA_UNPOWERED;
         next_act_stop = 1'b1;
         if (!(state inside {TLA_UNPOWERED, TLA_SENSING}))
            next_ind.disconnected_report = 1'b1;
         if (!(state inside {TLA_UNPOWERED, TLA_SENSING, TLA_DEACTIVATED})) begin
            next_ind.layer2_deactivation = 1'b1;
            next_ind.mgmt_deactivation = 1'b1;
         end
      end else begin
         case (state)
            TLA_UNPOWERED: next_state = TLA_SENSING;
            TLA_SENSING: begin
               if (rx_i.network_frame) begin
                  next_ind.connected_report = 1'b1;
                  next_ind.layer2_activation = 1'b1;
                  next_ind.mgmt_activation = 1'b1;
                  next_state = TLA_ACTIVATED;
               end else if (rx_i.idle_frame) begin
                  next_ind.connected_report = 1'b1;
                  next_state = TLA_SYNCHRONIZED;
               end else if (rx_i.silence) begin
                  next_ind.connected_report = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end
            end
            TLA_DEACTIVATED: begin
               if (rx_i.network_frame) begin
                  next_ind.layer2_activation = 1'b1;
                  next_ind.mgmt_activation = 1'b1;
                  next_state = TLA_ACTIVATED;
               end else if (rx_i.idle_frame) begin
                  next_state = TLA_SYNCHRONIZED;
               end else if (activation_request_i) begin
                  next_act_start = 1'b1;
                  next_state = TLA_AWAITING;
               end
            end
            TLA_AWAITING: begin
               if (act_expired) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end else if (rx_i.any_signal || rx_i.idle_frame || rx_i.network_frame) begin
                  next_state = TLA_IDENTIFYING;
               end
            end
            TLA_IDENTIFYING: begin
               if (act_expired) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end else if (rx_i.network_frame) begin
                  next_ind.layer2_activation = 1'b1;
                  next_ind.mgmt_activation = 1'b1;
                  next_act_stop = 1'b1;
                  next_state = TLA_ACTIVATED;
               end else if (rx_i.idle_frame) begin
                  next_state = TLA_SYNCHRONIZED;
               end
            end
            TLA_SYNCHRONIZED: begin
               if (act_expired) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end else if (rx_i.frame_lost) begin
                  next_ind.mgmt_error = 1'b1;
                  next_state = TLA_LOST_FRAMING;
               end else if (rx_i.network_frame) begin
                  next_ind.layer2_activation = 1'b1;
                  next_ind.mgmt_activation = 1'b1;
                  next_act_stop = 1'b1;
                  next_state = TLA_ACTIVATED;
               end else if (rx_i.silence) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end
            end
            TLA_ACTIVATED: begin
               if (rx_i.frame_lost) begin
                  next_ind.mgmt_error = 1'b1;
                  next_state = TLA_LOST_FRAMING;
               end else if (rx_i.silence) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end else if (rx_i.idle_frame) begin
                  next_ind.mgmt_error = 1'b1;
                  next_state = TLA_SYNCHRONIZED;
               end
            end
            TLA_LOST_FRAMING: begin
               if (act_expired) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end else if (rx_i.network_frame) begin
                  next_ind.layer2_activation = 1'b1;
                  next_ind.mgmt_activation = 1'b1;
                  next_ind.mgmt_error = 1'b1;
                  next_act_stop = 1'b1;
                  next_state = TLA_ACTIVATED;
               end else if (rx_i.idle_frame) begin
                  next_ind.mgmt_error = 1'b1;
                  next_state = TLA_SYNCHRONIZED;
               end else if (rx_i.silence) begin
                  next_ind.layer2_deactivation = 1'b1;
                  next_ind.mgmt_deactivation = 1'b1;
                  next_state = TLA_DEACTIVATED;
               end
            end
            default: next_state = TLA_UNPOWERED;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i)
         state <= TLA_UNPOWERED;
      else if (ce_i)
         state <= next_state;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i)
         ind_o <= '0;
      else if (ce_i)
         ind_o <= next_ind;
      else
         ind_o <= '0;
   end

   // Timer counts down; stopping it on activation keeps a late expiry from firing
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         act_count <= '0;
         act_run <= 1'b0;
      end else if (ce_i) begin
         if (next_act_start) begin
            act_count <= TIMER_W'(ACT_CYCLES);
            act_run <= 1'b1;
         end else if (next_act_stop || act_expired || next_state == TLA_DEACTIVATED) begin
            act_run <= 1'b0;
         end else if (act_run) begin
            act_count <= act_count - 32'h1;
         end
      end
   end

   // Transmit choice is registered from next state: silence on power loss is immediate
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tx_sel_o <= TLA_TX_SILENCE;
         data_reliable_o <= 1'b0;
      end else if (ce_i) begin
         case (next_state)
            TLA_AWAITING: tx_sel_o <= TLA_TX_WAKEUP;
            TLA_SYNCHRONIZED, TLA_ACTIVATED: tx_sel_o <= TLA_TX_DATA;
            default: tx_sel_o <= TLA_TX_SILENCE;
         endcase
         data_reliable_o <= (next_state == TLA_ACTIVATED);
      end
   end

   tla_wakeup_gen u_wake (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .enable_i(tx_sel_o == TLA_TX_WAKEUP),
      .bit_tick_i(bit_tick_i),
      .symbol_o(wake_symbol_o)
   );

   sequence s_power_lost;
      ce_i && !power_i;
   endsequence

   property p_power_loss;
      @(posedge clk_i) disable iff (!nrst_i) s_power_lost |=> state == TLA_UNPOWERED
         && tx_sel_o == TLA_TX_SILENCE;
   endproperty
   a_power_loss : assert property (p_power_loss) else $error("power loss not handled");

   property p_power_up;
      @(posedge clk_i) disable iff (!nrst_i)
         ce_i && power_i && state == TLA_UNPOWERED |=> state == TLA_SENSING;
   endproperty
   a_power_up : assert property (p_power_up) else $error("no sensing on power");

   property p_tx_map;
      @(posedge clk_i) disable iff (!nrst_i)
         $past(ce_i) |-> (tx_sel_o == TLA_TX_WAKEUP) == (state == TLA_AWAITING);
   endproperty
   a_tx_map : assert property (p_tx_map) else $error("wakeup not tied to awaiting");

   property p_data_tx;
      @(posedge clk_i) disable iff (!nrst_i) $past(ce_i) && is_sync_or_later(state)
         |-> tx_sel_o == TLA_TX_DATA;
   endproperty
   a_data_tx : assert property (p_data_tx) else $error("no data frames when aligned");

   property p_req;
      @(posedge clk_i) disable iff (!nrst_i) ce_i && power_i && state == TLA_DEACTIVATED
         && activation_request_i && !rx_i.idle_frame && !rx_i.network_frame
         |=> state == TLA_AWAITING && act_run;
   endproperty
   a_req : assert property (p_req) else $error("request did not start timer");

   property p_identify;
      @(posedge clk_i) disable iff (!nrst_i) ce_i && power_i && state == TLA_AWAITING
         && !act_expired && rx_i.any_signal |=> state == TLA_IDENTIFYING;
   endproperty
   a_identify : assert property (p_identify) else $error("no identifying");

   property p_activate;
      @(posedge clk_i) disable iff (!nrst_i) ce_i && power_i && rx_i.network_frame
         && state == TLA_SYNCHRONIZED && !act_expired && !rx_i.frame_lost
         |=> state == TLA_ACTIVATED && ind_o.layer2_activation && !act_run;
   endproperty
   a_activate : assert property (p_activate) else $error("activation missed");

   property p_lost;
      @(posedge clk_i) disable iff (!nrst_i) ce_i && power_i && rx_i.frame_lost
         && state == TLA_ACTIVATED |=> state == TLA_LOST_FRAMING && ind_o.mgmt_error;
   endproperty
   a_lost : assert property (p_lost) else $error("lost framing missed");

   property p_reliable;
      @(posedge clk_i) disable iff (!nrst_i) data_reliable_o |-> state == TLA_ACTIVATED;
   endproperty
   a_reliable : assert property (p_reliable) else $error("reliable too early");
endmodule // tla_fsm
`default_nettype wire

// ==== verif/tla_nt_model.sv ====
/*
 Network terminator model facing the terminal activation state machine.
 Assumes the bench enables it only while it owns the receive events.
*/
`timescale 1ns/10ps
`default_nettype none
module tla_nt_model #(
   // Release timer, scaled down from its 25 ms to 100 ms span
   parameter int unsigned REL_CYCLES = 25
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Bench control
   input wire logic en_i,
   input wire logic release_i,
   input wire logic [7:0] dly_i,
   // Line
   input wire tla_pkg::tla_tx_type tx_sel_i,
   output tla_pkg::tla_rx_type rx_o
);
   import tla_pkg::*;
   tla_tx_type last_tx;
   logic [7:0] cnt;
   logic [7:0] rel_cnt;
   logic woke;

   // Events are one-cycle pulses; nothing is held once the model is idle
   always_ff @(posedge clk_i) begin
      rx_o <= '0;
      if (!nrst_i || !en_i) begin
         cnt <= 8'h00;
         rel_cnt <= 8'h00;
         woke <= 1'b0;
         last_tx <= TLA_TX_SILENCE;
      end else begin
         last_tx <= tx_sel_i;
         if (tx_sel_i != last_tx) begin
            cnt <= 8'h00;
         end else if (cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
         end
         if (release_i) begin
            if (rel_cnt != 8'hff) begin
               rel_cnt <= rel_cnt + 8'h01;
            end
            rx_o.silence <= (rel_cnt == REL_CYCLES[7:0]);
         end else if (tx_sel_i == last_tx && cnt == dly_i) begin
            case (tx_sel_i)
               TLA_TX_WAKEUP: begin
                  rx_o.any_signal <= 1'b1;
                  woke <= 1'b1;
               end
               TLA_TX_SILENCE: rx_o.idle_frame <= woke;
               default: rx_o.network_frame <= 1'b1;
            endcase
         end
      end
   end
endmodule // tla_nt_model
`default_nettype wire

// ==== verif/tb_terminal_line_activation_fsm.sv ====
/*
 Self-checking testbench for the terminal line activation state machine.
 Assumes tla_fsm as top, with the network terminator model on its line side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_terminal_line_activation_fsm;
   import tla_pkg::*;
   // Short activation timer keeps the run brief
   localparam int unsigned ACT = 50;
   localparam int unsigned REL = 25;
   typedef struct packed {
      logic pwr;
      logic req;
      logic [4:0] rx;
      logic [7:0] st;
      logic [1:0] tx;
      logic [6:0] ind;
   } tla_row_type;
   tla_row_type rows[$];
   logic clk, nrst, ce, power, act_req, bit_tick, nt_en, nt_rel;
   logic [7:0] nt_dly;
   tla_rx_type rx_tb, rx_nt, rx;
   tla_tx_type tx_sel;
   logic [1:0] wake_sym;
   logic reliable;
   tla_ind_type ind;
   tla_state_type state;
   int n_mismatch = 0;
   int check_count = 0;
   int n;

   assign rx = nt_en ? rx_nt : rx_tb;

   tla_fsm #(.ACT_CYCLES(ACT)) dut_u (.clk_i(clk), .nrst_i(nrst), .ce_i(ce), .power_i(power),
      .activation_request_i(act_req), .rx_i(rx), .bit_tick_i(bit_tick), .tx_sel_o(tx_sel),
      .wake_symbol_o(wake_sym), .data_reliable_o(reliable), .ind_o(ind), .state_o(state));
   tla_nt_model #(.REL_CYCLES(REL)) nt_u (.clk_i(clk), .nrst_i(nrst), .en_i(nt_en),
      .release_i(nt_rel), .dly_i(nt_dly), .tx_sel_i(tx_sel), .rx_o(rx_nt));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic expect_out(input logic [7:0] st, input logic [1:0] tx, input logic [6:0] i);
      check(state, st, "state");
      check(tx_sel, tx, "tx select");
      check(ind, i, "indications");
      check(reliable, st == 8'h40, "reliable");
   endtask

   task automatic r(input logic p, input logic q, input logic [4:0] e, input logic [7:0] st,
      input logic [1:0] tx, input logic [6:0] i);
      rows.push_back({p, q, e, st, tx, i});
   endtask

   task automatic pulse(input logic p, input logic q, input logic [4:0] e);
      @(posedge clk);
      power <= p;
      act_req <= q;
      rx_tb <= e;
      @(posedge clk);
      act_req <= 1'b0;
      rx_tb <= '0;
      #1;
   endtask

   task automatic wait_state(input tla_state_type st, input int bound, output int k);
      k = 0;
      while (state !== st) begin
         @(posedge clk);
         #1;
         k++;
         if (k > bound) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout waiting for state %h", $time, st);
            report_and_stop();
         end
      end
   endtask

   task automatic handshake(input logic [7:0] dly);
      @(posedge clk);
      nt_dly <= dly;
      nt_en <= 1'b1;
      pulse(1'b1, 1'b1, 5'h00);
      wait_state(TLA_ACTIVATED, 60, n);
      check(reliable, 1'b1, "reliable after frames");
      $display("test handshake done");
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
   end

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      power = 1'b0;
      act_req = 1'b0;
      bit_tick = 1'b0;
      nt_en = 1'b0;
      nt_rel = 1'b0;
      nt_dly = 8'h01;
      rx_tb = '0;
      repeat (4) @(posedge clk);
      #1;
      expect_out(8'h01, 2'h0, 7'h00);
      @(posedge clk);
      nrst <= 1'b1;
      r(1, 0, 5'h00, 8'h02, 2'h0, 7'h00);
      r(1, 1, 5'h00, 8'h02, 2'h0, 7'h00);
      r(1, 0, 5'h01, 8'h04, 2'h0, 7'h04);
      r(1, 1, 5'h00, 8'h08, 2'h1, 7'h00);
      r(1, 0, 5'h10, 8'h10, 2'h0, 7'h00);
      r(1, 0, 5'h08, 8'h20, 2'h2, 7'h00);
      r(1, 0, 5'h04, 8'h40, 2'h2, 7'h60);
      r(1, 0, 5'h02, 8'h80, 2'h0, 7'h01);
      r(1, 0, 5'h04, 8'h40, 2'h2, 7'h61);
      r(1, 0, 5'h01, 8'h04, 2'h0, 7'h18);
      r(1, 0, 5'h08, 8'h20, 2'h2, 7'h00);
      r(1, 0, 5'h04, 8'h40, 2'h2, 7'h60);
      r(1, 0, 5'h08, 8'h20, 2'h2, 7'h01);
      r(1, 0, 5'h04, 8'h40, 2'h2, 7'h60);
      r(0, 0, 5'h02, 8'h01, 2'h0, 7'h1a);
      r(1, 0, 5'h00, 8'h02, 2'h0, 7'h00);
      r(1, 0, 5'h04, 8'h40, 2'h2, 7'h64);
      r(1, 0, 5'h02, 8'h80, 2'h0, 7'h01);
      r(1, 0, 5'h01, 8'h04, 2'h0, 7'h18);
      r(0, 0, 5'h00, 8'h01, 2'h0, 7'h02);
      r(1, 0, 5'h00, 8'h02, 2'h0, 7'h00);
      r(1, 0, 5'h01, 8'h04, 2'h0, 7'h04);
      foreach (rows[i]) begin
         pulse(rows[i].pwr, rows[i].req, rows[i].rx);
         expect_out(rows[i].st, rows[i].tx, rows[i].ind);
      end
      $display("test table done");
      // A frozen enable must hold the request off
      @(posedge clk);
      ce <= 1'b0;
      act_req <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      expect_out(8'h04, 2'h0, 7'h00);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      act_req <= 1'b0;
      #1;
      expect_out(8'h08, 2'h1, 7'h00);
      $display("test enable done");
      wait_state(TLA_DEACTIVATED, ACT + 10, n);
      check(n >= ACT - 2 && n <= ACT + 1, 1'b1, "timer span");
      check(ind, 7'h18, "expiry indications");
      check(ACT_TIMER_CYCLES < 30 * CLK_HZ, 1'b1, "timer limit");
      $display("test timer done");
      pulse(1'b1, 1'b1, 5'h00);
      @(posedge clk);
      #1;
      // Seventeen ticks end on a positive zero, so the stop check below has teeth
      for (int k = 0; k < 17; k++) begin
         @(posedge clk);
         bit_tick <= 1'b1;
         @(posedge clk);
         bit_tick <= 1'b0;
         #1;
         check(wake_sym, (k % 8 == 0) ? 2'h1 : (k % 8 == 1) ? 2'h2 : 2'h0, "wake");
      end
      pulse(1'b1, 1'b0, 5'h10);
      expect_out(8'h10, 2'h0, 7'h00);
      // The generator sees the registered select one edge later
      @(posedge clk);
      #1;
      check(wake_sym, 2'h0, "wake stopped");
      wait_state(TLA_DEACTIVATED, ACT, n);
      check(ind, 7'h18, "expiry from identifying");
      $display("test wakeup done");
      handshake(8'h01);
      @(posedge clk);
      nrst <= 1'b0;
      nt_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      expect_out(8'h01, 2'h0, 7'h00);
      @(posedge clk);
      nrst <= 1'b1;
      pulse(1'b1, 1'b0, 5'h00);
      pulse(1'b1, 1'b0, 5'h01);
      expect_out(8'h04, 2'h0, 7'h04);
      $display("test reset done");
      handshake(8'h08);
      repeat (ACT + 5) @(posedge clk);
      #1;
      check(state, TLA_ACTIVATED, "timer stopped");
      @(posedge clk);
      nt_rel <= 1'b1;
      wait_state(TLA_DEACTIVATED, REL + 10, n);
      check(ind, 7'h18, "release indications");
      @(posedge clk);
      nt_rel <= 1'b0;
      nt_en <= 1'b0;
      $display("test release done");
      report_and_stop();
   end
endmodule // tb_terminal_line_activation_fsm
`default_nettype wire
